// ===== verilog/lpur_params.svh
`ifndef LPUR_PARAMS_SVH
`define LPUR_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define LPUR_OFS_CTRL 8'h00
`define LPUR_OFS_BAUD 8'h04
`define LPUR_OFS_PRESC 8'h08
`define LPUR_OFS_STATUS 8'h0C
`define LPUR_OFS_ICLR 8'h10
`define LPUR_OFS_REQ 8'h14
`define LPUR_OFS_DATA 8'h18

// ==========================================================
// Control register fields
`define LPUR_CTRL_W 12
`define LPUR_C_BLOCK_ON 0
`define LPUR_C_RX_ON 1
`define LPUR_C_CHAR_LEN 2
`define LPUR_C_PARITY_ON 3
`define LPUR_C_PARITY_ODD 4
`define LPUR_C_STOP_TWO 5
`define LPUR_C_RX_INV 6
`define LPUR_C_SINGLE_WIRE 7
`define LPUR_C_PIN_SWAP 8
`define LPUR_C_DMA_ON 9
`define LPUR_C_FULL_IRQ 10
`define LPUR_C_ERR_IRQ 11

// ==========================================================
// Status, clear and request fields
`define LPUR_S_FULL 0
`define LPUR_S_OVERRUN 1
`define LPUR_S_FRAME 2
`define LPUR_S_PARITY 3
`define LPUR_S_ACK 4
`define LPUR_S_BUSY 5
`define LPUR_R_FLUSH 0

// ==========================================================
// Widths and reset values
`define LPUR_DIV_W 20
`define LPUR_ACC_W 21
`define LPUR_PRE_W 8
`define LPUR_CTRL_RST 12'h000
`define LPUR_BAUD_RST 20'h00300
`define LPUR_PRE_RST 8'h01
`define LPUR_ACC_STEP 21'h000100
`define LPUR_BITS_SHORT 4'h7
`define LPUR_BITS_LONG 4'h8

`endif

// ===== verilog/lpur_pkg.sv
package lpur_pkg;

  // ==========================================================
  // Receiver sequencing
  typedef enum logic [1:0] {
    LPUR_R_IDLE,
    LPUR_R_START,
    LPUR_R_BITS,
    LPUR_R_STOP
  } lpur_rx_state_t;

  typedef struct packed {
    logic full;
    logic overrun;
    logic frame;
    logic parity;
  } lpur_flags_t;

  // ==========================================================
  // Whole block state
  typedef struct packed {
    logic [11:0] ctrl;
    logic [19:0] baud_divisor;
    logic [7:0] kernel_prescaler;
    logic [7:0] pre_cnt;
    logic [20:0] acc;
    lpur_rx_state_t rx_state;
    logic [3:0] bit_cnt;
    logic stop_first;
    logic [8:0] shift;
    logic [8:0] data;
    lpur_flags_t flags;
    logic line_q;
    logic rx_on_ack;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic dma_req;
    logic tx_pin_oe;
    logic tx_pin_out;
    logic rx_pin_oe;
    logic rx_pin_out;
  } lpur_state_t;

endpackage : lpur_pkg

// ===== verilog/lpur_rx.sv
`include "lpur_params.svh"

module lpur_rx (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin_in,
  output logic rx_pin_oe,
  output logic rx_pin_out,
  input wire logic tx_pin_in,
  output logic tx_pin_oe,
  output logic tx_pin_out,
  input wire logic tx_active,
  input wire logic tx_bit,
  output logic irq,
  output logic dma_req
);

  // ==========================================================
  // Register decode helpers
  function automatic logic lpur_mapped(input logic [7:0] a);
    case (a)
      `LPUR_OFS_CTRL, `LPUR_OFS_BAUD, `LPUR_OFS_PRESC, `LPUR_OFS_STATUS,
      `LPUR_OFS_ICLR, `LPUR_OFS_REQ, `LPUR_OFS_DATA: lpur_mapped = 1'b1;
      default: lpur_mapped = 1'b0;
    endcase
  endfunction : lpur_mapped

  function automatic logic [31:0] lpur_read(input logic [7:0] a, input lpur_pkg::lpur_state_t st);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `LPUR_OFS_CTRL: v[`LPUR_CTRL_W-1:0] = st.ctrl;
      `LPUR_OFS_BAUD: v[`LPUR_DIV_W-1:0] = st.baud_divisor;
      `LPUR_OFS_PRESC: v[`LPUR_PRE_W-1:0] = st.kernel_prescaler;
      `LPUR_OFS_STATUS: begin
        v[`LPUR_S_FULL] = st.flags.full;
        v[`LPUR_S_OVERRUN] = st.flags.overrun;
        v[`LPUR_S_FRAME] = st.flags.frame;
        v[`LPUR_S_PARITY] = st.flags.parity;
        v[`LPUR_S_ACK] = st.rx_on_ack;
        v[`LPUR_S_BUSY] = (st.rx_state != lpur_pkg::LPUR_R_IDLE);
      end
      // Old value stays readable during overrun
      `LPUR_OFS_DATA: v[8:0] = st.data;
      default: v = 32'h0000_0000;
    endcase
    lpur_read = v;
  endfunction : lpur_read

  lpur_pkg::lpur_state_t s;
  lpur_pkg::lpur_state_t next_s;

  logic running;
  logic two_stops;
  logic shared_sel;
  logic line_raw;
  logic line_now;
  logic fall;
  logic tick;
  logic sample;
  logic [20:0] acc_sum;
  logic [7:0] pre_div;
  logic [3:0] last_bit;
  logic [8:0] word;
  logic par_bad;
  logic stop_bad;
  logic done;
  logic acc_hit;
  logic bus_prep;
  logic bus_done;
  logic held;

  assign running = s.ctrl[`LPUR_C_BLOCK_ON] & s.ctrl[`LPUR_C_RX_ON];
  assign two_stops = s.ctrl[`LPUR_C_STOP_TWO];
  assign bus_prep = psel & penable & ~s.pready;
  assign bus_done = psel & penable & s.pready;

  // A DMA request still pending counts as unread
  assign held = s.flags.full | s.dma_req;

  // ==========================================================
  // Line selection and polarity
  // Pins are taken as synchronous to clk, no extra stages
  always_comb begin
    shared_sel = s.ctrl[`LPUR_C_PIN_SWAP];
    if (s.ctrl[`LPUR_C_SINGLE_WIRE]) begin
      line_raw = shared_sel ? rx_pin_in : tx_pin_in;
    end else begin
      line_raw = shared_sel ? tx_pin_in : rx_pin_in;
    end
    line_now = line_raw ^ s.ctrl[`LPUR_C_RX_INV];
  end

  assign fall = s.line_q & ~line_now;

  // ==========================================================
  // Kernel prescaler and fractional bit timing
  // Zero prescaler acts as divide by one, no stall
  // Below the legal divisor floor a bit spans too few ticks
  assign pre_div = (s.kernel_prescaler == 8'h00) ? 8'h01 : s.kernel_prescaler;
  assign tick = (s.pre_cnt >= pre_div - 8'h01);
  assign acc_sum = s.acc + `LPUR_ACC_STEP;
  // One bit lasts divisor/256 scaled ticks
  assign acc_hit = acc_sum >= {1'b0, s.baud_divisor};
  assign sample = tick & acc_hit;

  // ==========================================================
  // Character assembly
  assign last_bit = s.ctrl[`LPUR_C_CHAR_LEN] ? `LPUR_BITS_LONG : `LPUR_BITS_SHORT;
  always_comb begin
    if (s.ctrl[`LPUR_C_CHAR_LEN]) begin
      word = s.shift;
    end else begin
      word = {1'b0, s.shift[8:1]};
    end
    par_bad = s.ctrl[`LPUR_C_PARITY_ON] & ((^word) ^ s.ctrl[`LPUR_C_PARITY_ODD]);
    stop_bad = ~line_now;
    done = 1'b0;
    if (running && sample && s.rx_state == lpur_pkg::LPUR_R_STOP) begin
      // Only the last stop bit is checked
      done = ~(two_stops & s.stop_first);
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.line_q = line_now;
    next_s.rx_on_ack = running;

    // ==========================================================
    // Bus slave: one wait cycle, then effects on the completing edge
    // Read data is latched in the wait cycle and held until the next wait cycle
    if (bus_prep) begin
      next_s.pready = 1'b1;
      next_s.pslverr = ~lpur_mapped(paddr);
      next_s.prdata = pwrite ? 32'h0000_0000 : lpur_read(paddr, s);
    end else begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end

    if (bus_done && pwrite) begin
      case (paddr)
        `LPUR_OFS_CTRL: next_s.ctrl = pwdata[`LPUR_CTRL_W-1:0];
        `LPUR_OFS_BAUD: next_s.baud_divisor = pwdata[`LPUR_DIV_W-1:0];
        `LPUR_OFS_PRESC: next_s.kernel_prescaler = pwdata[`LPUR_PRE_W-1:0];
        `LPUR_OFS_ICLR: begin
          if (pwdata[`LPUR_S_OVERRUN]) begin
            next_s.flags.overrun = 1'b0;
          end
          if (pwdata[`LPUR_S_FRAME]) begin
            next_s.flags.frame = 1'b0;
          end
          if (pwdata[`LPUR_S_PARITY]) begin
            next_s.flags.parity = 1'b0;
          end
        end
        `LPUR_OFS_REQ: begin
          if (pwdata[`LPUR_R_FLUSH]) begin
            next_s.flags.full = 1'b0;
          end
        end
        default: next_s.flags = next_s.flags;
      endcase
    end
    // CPU or DMA read of the data register drains it
    if (bus_done && !pwrite && paddr == `LPUR_OFS_DATA) begin
      next_s.flags.full = 1'b0;
    end

    // ==========================================================
    // Prescaler counter
    if (tick) begin
      next_s.pre_cnt = 8'h00;
    end else begin
      next_s.pre_cnt = s.pre_cnt + 8'h01;
    end

    if (tick) begin
      if (acc_hit) begin
        next_s.acc = acc_sum - {1'b0, s.baud_divisor};
      end else begin
        next_s.acc = acc_sum;
      end
    end

    // ==========================================================
    // Receiver sequencing
    if (!running) begin
      next_s.rx_state = lpur_pkg::LPUR_R_IDLE;
      // Abandoned frame leaves no half-counted stop behind
      next_s.stop_first = 1'b0;
    end else begin
      case (s.rx_state)
        lpur_pkg::LPUR_R_IDLE: begin
          if (fall) begin
            // Half a bit consumed so the next hit lands mid start
            next_s.acc = {2'b00, s.baud_divisor[19:1]};
            next_s.pre_cnt = 8'h00;
            next_s.rx_state = lpur_pkg::LPUR_R_START;
          end
        end
        lpur_pkg::LPUR_R_START: begin
          if (sample) begin
            if (!line_now) begin
              next_s.rx_state = lpur_pkg::LPUR_R_BITS;
              next_s.bit_cnt = 4'h0;
            end else begin
              next_s.rx_state = lpur_pkg::LPUR_R_IDLE;
            end
          end
        end
        lpur_pkg::LPUR_R_BITS: begin
          if (sample) begin
            // Parity, when on, arrives as the last data bit
            next_s.shift = {line_now, s.shift[8:1]};
            if (s.bit_cnt == last_bit) begin
              next_s.rx_state = lpur_pkg::LPUR_R_STOP;
              next_s.stop_first = 1'b1;
            end else begin
              next_s.bit_cnt = s.bit_cnt + 4'h1;
            end
          end
        end
        lpur_pkg::LPUR_R_STOP: begin
          if (sample) begin
            next_s.stop_first = 1'b0;
            if (done) begin
              next_s.rx_state = lpur_pkg::LPUR_R_IDLE;
            end
          end
        end
        default: next_s.rx_state = lpur_pkg::LPUR_R_IDLE;
      endcase
    end

    // ==========================================================
    // Character completion; hardware set wins over a same-cycle clear
    if (done) begin
      if (held) begin
        // Shift register only; the held character is not replaced
        next_s.flags.overrun = 1'b1;
      end else begin
        next_s.data = word;
        next_s.flags.full = 1'b1;
        if (stop_bad) begin
          next_s.flags.frame = 1'b1;
        end
        if (par_bad) begin
          next_s.flags.parity = 1'b1;
        end
      end
    end

    // ==========================================================
    // Flags live in the bus clock domain already, no crossing needed
    next_s.irq = (s.ctrl[`LPUR_C_FULL_IRQ] & (next_s.flags.full | next_s.flags.overrun))
      | (s.ctrl[`LPUR_C_ERR_IRQ] & (next_s.flags.overrun | next_s.flags.frame
      | next_s.flags.parity));
    next_s.dma_req = s.ctrl[`LPUR_C_DMA_ON] & next_s.flags.full;

    // ==========================================================
    // Pin drive: open drain on the shared line, pulls low only
    next_s.tx_pin_oe = 1'b0;
    next_s.tx_pin_out = 1'b0;
    next_s.rx_pin_oe = 1'b0;
    next_s.rx_pin_out = 1'b0;
    if (s.ctrl[`LPUR_C_BLOCK_ON]) begin
      if (s.ctrl[`LPUR_C_SINGLE_WIRE]) begin
        if (shared_sel) begin
          next_s.rx_pin_oe = tx_active & ~tx_bit;
        end else begin
          next_s.tx_pin_oe = tx_active & ~tx_bit;
        end
      end else if (shared_sel) begin
        next_s.rx_pin_oe = 1'b1;
        next_s.rx_pin_out = tx_active ? tx_bit : 1'b1;
      end else begin
        next_s.tx_pin_oe = 1'b1;
        next_s.tx_pin_out = tx_active ? tx_bit : 1'b1;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.ctrl <= `LPUR_CTRL_RST;
      s.baud_divisor <= `LPUR_BAUD_RST;
      s.kernel_prescaler <= `LPUR_PRE_RST;
      s.rx_state <= lpur_pkg::LPUR_R_IDLE;
      s.line_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign dma_req = s.dma_req;
  assign tx_pin_oe = s.tx_pin_oe;
  assign tx_pin_out = s.tx_pin_out;
  assign rx_pin_oe = s.rx_pin_oe;
  assign rx_pin_out = s.rx_pin_out;

endmodule : lpur_rx

// ===== tb/lpur_line_model.sv
module lpur_line_model (
  input wire logic clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_clks = 8;
  logic inv = 1'b0;
  initial line = 1'b1;
  // ==========================================================
  // Remote sender; the line has a pull-up, so idle is the stop level
  task automatic idle;
    line <= ~inv;
  endtask : idle
  task automatic hold(input logic v);
    line <= v ^ inv;
    repeat (bit_clks) @(posedge clk);
  endtask : hold
  // A low stop level is how the bench forces a framing fault
  task automatic send(input logic [8:0] dd, input int n, input int nst, input logic s1,
                      input logic s2);
    hold(1'b0);
    for (int i = 0; i < n; i++) begin
      hold(dd[i]);
    end
    if (nst == 2) begin
      hold(s1);
    end
    hold(s2);
    idle;
  endtask : send
endmodule : lpur_line_model

// ===== tb/lpur_rx_chk.sv
`include "lpur_params.svh"
module lpur_rx_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_pin_in,
  input wire logic rx_pin_oe,
  input wire logic rx_pin_out,
  input wire logic tx_pin_in,
  input wire logic tx_pin_oe,
  input wire logic tx_pin_out,
  input wire logic tx_active,
  input wire logic tx_bit,
  input wire logic irq,
  input wire logic dma_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Control mirror, taken only from committed bus writes
  logic [11:0] ctl;
  logic [11:0] next_ctl;
  always_comb begin
    next_ctl = ctl;
    if (psel && penable && pready && pwrite && paddr == `LPUR_OFS_CTRL) begin
      next_ctl = pwdata[11:0];
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= 12'h000;
    end else begin
      ctl <= next_ctl;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_one_wait; s_wait |=> s_answer; endproperty
  property p_unmapped; psel && penable && !pready && paddr > 8'h18 |=> pslverr && prdata == 32'h0;
  endproperty
  property p_irq_off; ctl[11:10] == 2'b00 && $past(ctl[11:10]) == 2'b00 |-> !irq; endproperty
  property p_dma_off; !ctl[9] && !$past(ctl[9]) |-> !dma_req; endproperty
  property p_dma_irq; ctl[10] && $past(ctl[10]) && dma_req |-> irq; endproperty
  property p_sw_drive; ctl[0] && ctl[7] && !ctl[8] && tx_active && !tx_bit
    |=> tx_pin_oe && !tx_pin_out && !rx_pin_oe; endproperty
  property p_swap; ctl[0] && ctl[7] && ctl[8] && tx_active && !tx_bit
    |=> rx_pin_oe && !rx_pin_out && !tx_pin_oe; endproperty
  property p_sw_release; ctl[7] && !tx_active |=> !tx_pin_oe && !rx_pin_oe; endproperty
  property p_fd_idle; ctl[0] && !ctl[7] && !ctl[8] && !tx_active
    |=> tx_pin_oe && tx_pin_out && !rx_pin_oe; endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready not one cycle late");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  a_dma_off: assert property (p_dma_off) else $error("dma_req without dma");
  a_dma_irq: assert property (p_dma_irq) else $error("full without irq");
  a_sw_drive: assert property (p_sw_drive) else $error("shared pin not driven");
  a_swap: assert property (p_swap) else $error("swapped pin not driven");
  a_sw_release: assert property (p_sw_release) else $error("pin not released");
  a_fd_idle: assert property (p_fd_idle) else $error("idle transmit pin not high");
endmodule : lpur_rx_chk

// ===== tb/lowpower_uart_receiver_tb.sv
`include "lpur_params.svh"
module lowpower_uart_receiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, psel, penable, pwrite, tx_active, tx_bit, line, e, a_r, b_r;
  logic pready, pslverr, rx_pin_in, rx_pin_oe, rx_pin_out, tx_pin_in, tx_pin_oe, tx_pin_out;
  logic irq, dma_req, ef, eo, efe, epe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] d;
  int n_mismatch = 0;
  int tests_run = 0;
  int ct, nb;
  int exp_q[$];
  // Open-drain pins with pull-up: any low driver wins
  assign rx_pin_in = line & ~(rx_pin_oe & ~rx_pin_out);
  assign tx_pin_in = line & ~(tx_pin_oe & ~tx_pin_out);
  lpur_rx i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin_in(rx_pin_in), .rx_pin_oe(rx_pin_oe), .rx_pin_out(rx_pin_out),
    .tx_pin_in(tx_pin_in), .tx_pin_oe(tx_pin_oe), .tx_pin_out(tx_pin_out),
    .tx_active(tx_active), .tx_bit(tx_bit), .irq(irq), .dma_req(dma_req));
  lpur_line_model i_line (.clk(clk), .line(line));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // Bus, model and compare tasks
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic setc(input int c);
    ct = c;
    apb(1'b1, `LPUR_OFS_CTRL, 32'(c));
  endtask : setc
  task automatic check_state;
    apb(1'b0, `LPUR_OFS_STATUS, 32'h0);
    chk("status", 32'({1'b0, ct[1] & ct[0], epe, efe, eo, ef}), 32'(r[5:0]));
    chk("irq", 32'(ct[10] & (ef | eo) | ct[11] & (eo | efe | epe)), 32'(irq));
    chk("dma_req", 32'(ct[9] & ef), 32'(dma_req));
  endtask : check_state
  task automatic rx_char(input logic [8:0] dd, input int nst, input logic s1, input logic s2,
                         input logic pe);
    i_line.send(dd, nb, nst, s1, s2);
    repeat (2) @(posedge clk);
    if (ef) begin
      eo = 1'b1;
    end else begin
      ef = 1'b1;
      exp_q.push_back(int'(dd));
      efe = efe | ~s2;
      epe = epe | pe;
    end
    check_state;
  endtask : rx_char
  task automatic rd_data;
    apb(1'b0, `LPUR_OFS_DATA, 32'h0);
    chk("data", 32'(exp_q[0]), r);
    void'(exp_q.pop_front());
    ef = 1'b0;
  endtask : rd_data
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h43DF));
    {rst_b, psel, penable, pwrite, tx_active, tx_bit, ef, eo, efe, epe} = 10'h000;
    paddr = 8'h00;
    pwdata = 32'h0;
    ct = 0;
    nb = 8;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `LPUR_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0, r);
    apb(1'b0, `LPUR_OFS_BAUD, 32'h0);
    chk("baud", 32'h300, r);
    apb(1'b0, `LPUR_OFS_PRESC, 32'h0);
    chk("presc", 32'h1, r);
    apb(1'b0, 8'h1C, 32'h0);
    chk("pslverr", 32'h1, 32'(e));
    apb(1'b1, `LPUR_OFS_BAUD, 32'h800);
    for (int len = 0; len < 2; len++) begin
      setc(32'h3 | len << 2);
      nb = 8 + len;
      repeat (3) begin
        d = 9'($urandom()) & (len != 0 ? 9'h1FF : 9'h0FF);
        rx_char(d, 1, 1'b1, 1'b1, 1'b0);
        rd_data;
      end
    end
    nb = 8;
    setc(32'h3);
    i_line.bit_clks = 2;
    i_line.hold(1'b0);
    i_line.bit_clks = 8;
    i_line.hold(1'b1);
    check_state;
    $display("Test characters done");
    setc(32'h403);
    rx_char(9'h05A, 1, 1'b1, 1'b1, 1'b0);
    rx_char(9'h0A5, 1, 1'b1, 1'b1, 1'b0);
    rd_data;
    check_state;
    apb(1'b1, `LPUR_OFS_ICLR, 32'h2);
    eo = 1'b0;
    rx_char(9'h03C, 1, 1'b1, 1'b1, 1'b0);
    apb(1'b1, `LPUR_OFS_REQ, 32'h1);
    ef = 1'b0;
    void'(exp_q.pop_front());
    check_state;
    setc(32'h803);
    rx_char(9'h0C3, 1, 1'b1, 1'b0, 1'b0);
    rd_data;
    apb(1'b1, `LPUR_OFS_ICLR, 32'h4);
    efe = 1'b0;
    setc(32'h823);
    for (int s = 0; s < 2; s++) begin
      rx_char(9'($urandom()) & 9'h0FF, 2, s[0], ~s[0], 1'b0);
      rd_data;
      apb(1'b1, `LPUR_OFS_ICLR, 32'h4);
      efe = 1'b0;
    end
    $display("Test errors done");
    for (int odd = 0; odd < 2; odd++) begin
      setc(32'h80B | odd << 4);
      for (int k = 0; k < 2; k++) begin
        d = 9'($urandom()) & 9'h07F;
        // One good and one bad parity bit for each sense
        d[7] = ^d[6:0] ^ odd[0] ^ k[0];
        rx_char(d, 1, 1'b1, 1'b1, ^d[7:0] ^ odd[0]);
        rd_data;
        apb(1'b1, `LPUR_OFS_ICLR, 32'h8);
        epe = 1'b0;
      end
    end
    setc(32'h603);
    rx_char(9'h099, 1, 1'b1, 1'b1, 1'b0);
    rd_data;
    check_state;
    apb(1'b1, `LPUR_OFS_PRESC, 32'h2);
    apb(1'b1, `LPUR_OFS_BAUD, 32'h400);
    rx_char(9'h0E7, 1, 1'b1, 1'b1, 1'b0);
    rd_data;
    apb(1'b1, `LPUR_OFS_PRESC, 32'h1);
    apb(1'b1, `LPUR_OFS_BAUD, 32'h800);
    setc(32'h41);
    i_line.inv = 1'b1;
    i_line.idle;
    setc(32'h43);
    rx_char(9'h01E, 1, 1'b1, 1'b1, 1'b0);
    rd_data;
    setc(32'h1);
    i_line.inv = 1'b0;
    i_line.idle;
    $display("Test modes done");
    for (int sw = 0; sw < 2; sw++) begin
      setc(32'h83 | sw << 8);
      rx_char(9'($urandom()) & 9'h0FF, 1, 1'b1, 1'b1, 1'b0);
      rd_data;
      setc(32'h81 | sw << 8);
      repeat (16) begin
        a_r = 1'($urandom());
        b_r = 1'($urandom());
        tx_active <= a_r;
        tx_bit <= b_r;
        repeat (2) @(posedge clk);
        chk("pin_oe", 32'(a_r & ~b_r), 32'(sw != 0 ? rx_pin_oe : tx_pin_oe));
      end
      tx_active <= 1'b0;
    end
    $display("Test single wire done");
    final_report;
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule : lowpower_uart_receiver_tb
bind lpur_rx lpur_rx_chk i_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_pin_in(rx_pin_in), .rx_pin_oe(rx_pin_oe), .rx_pin_out(rx_pin_out),
  .tx_pin_in(tx_pin_in), .tx_pin_oe(tx_pin_oe), .tx_pin_out(tx_pin_out),
  .tx_active(tx_active), .tx_bit(tx_bit), .irq(irq), .dma_req(dma_req));
